// file: rtl/ictcs_defs.vh
// constants for the input clock and time code selector
`ifndef ICTCS_DEFS_VH
`define ICTCS_DEFS_VH
// master clock setting codes
`define ICTCS_CLK_INTERNAL 2'h0
`define ICTCS_CLK_DIGITAL 2'h1
`define ICTCS_CLK_EXTERNAL 2'h2
// reported clock source codes
`define ICTCS_SRC_INTERNAL 2'h0
`define ICTCS_SRC_DIGITAL 2'h1
`define ICTCS_SRC_VIDEO 2'h2
`define ICTCS_SRC_WORD 2'h3
// frame rate codes
`define ICTCS_FR_23976 3'h0
`define ICTCS_FR_24 3'h1
`define ICTCS_FR_25 3'h2
`define ICTCS_FR_2997 3'h3
`define ICTCS_FR_2997DF 3'h4
`define ICTCS_FR_30DF 3'h5
`define ICTCS_FR_30 3'h6
// generator modes
`define ICTCS_GEN_RTC 2'h0
`define ICTCS_GEN_CONTINUE 2'h1
`define ICTCS_GEN_FREE 2'h2
`define ICTCS_GEN_EXTERNAL 2'h3
// time code field limits
`define ICTCS_TC_W 32
`define ICTCS_TC_ZERO 32'h00000000
`define ICTCS_HOUR_MAX 8'h17
`define ICTCS_MIN_MAX 8'h3b
`define ICTCS_SEC_MAX 8'h3b
`define ICTCS_ZERO8 8'h00
`define ICTCS_ONE8 8'h01
`define ICTCS_TWO8 8'h02
`define ICTCS_TEN8 8'h0a
// last frame number within a second, per frame count
`define ICTCS_FMAX_24 8'h17
`define ICTCS_FMAX_25 8'h18
`define ICTCS_FMAX_30 8'h1d
`define ICTCS_ONE16 16'h0001
// reference presence timeout, in system clock cycles
`define ICTCS_REF_TIMEOUT 16'h0400
`define ICTCS_REF_TO_ZERO 16'h0000
`endif

// file: rtl/ictcs_sync.v
// two-stage synchroniser with edge detection for a bus of inputs
`timescale 1ns/100ps
module ictcs_sync #(
  parameter WIDTH = 1
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] rise_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] prev_reg;

  // first stage feeds only the second
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
      prev_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~prev_reg;
endmodule

// file: rtl/ictcs_top.v
// input source, master clock and time code generator selection
`timescale 1ns/100ps
`include "ictcs_defs.vh"

// Summary of operation
// - default configuration prefers digital input on all six channels
// - each pair takes digital only while its digital input is locked
// - unlocked pair falls back to analog automatically
// - per-pair setting forces digital or analog independently only while the default configuration is off
// - clock set digital and locked reports digital source and icon
// - clock set digital but unlocked runs and reports internal clock
// - external setting detects video or word reference and reports it
// - seven selectable frame rates including two drop-frame ones
// - generator advances one frame per rising edge of the frame tick input while recording or in free mode
// - thirty and drop-frame settings drift 3.6 seconds per hour
// - no continuity required across the midnight rollover for those
// - flash frame rate on incoming view when external rate differs
// - mode switch picks one of four generator modes
// - rtc start mode loads real-time clock value at record start
// - continue mode resumes from the last recorded value
// - external start mode loads incoming time code at record start while it is valid, otherwise keeps the current value
module ictcs_top #(
  parameter PAIRS = 3,
  parameter FLASH_DIV = 24
) (
  input wire clk_sys,
  input wire rst,
  input wire [PAIRS-1:0] pair_digital_cfg,
  input wire cfg_default,
  input wire [PAIRS-1:0] dig_lock_in,
  input wire [1:0] master_clock_sel,
  input wire video_ref_in,
  input wire word_ref_in,
  input wire [2:0] frame_rate_sel,
  input wire [2:0] incoming_frame_rate,
  input wire incoming_tc_valid,
  input wire [31:0] incoming_tc_value,
  input wire [31:0] rtc_value,
  input wire [1:0] timecode_generator_mode_switch,
  input wire record_active,
  input wire incoming_timecode_view,
  input wire frame_tick_in,
  output reg [PAIRS-1:0] pair_use_digital,
  output reg [1:0] clock_source,
  output reg digital_lock_indicator,
  output reg digital_icon,
  output reg internal_clock_indicator,
  output reg [31:0] tc_value,
  output reg [2:0] tc_rate,
  output reg tc_drop_frame,
  output reg rate_flash
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  wire [PAIRS-1:0] lock_s;
  wire [2:0] ref_rise;
  wire [PAIRS-1:0] want_dig;
  wire [2:0] asy_bus;
  wire [PAIRS-1:0] pair_next;

  ////////////////////////////////////////////////////////////
  // synchronise pin inputs
  assign asy_bus = {frame_tick_in, word_ref_in, video_ref_in};

  // only lock levels matter, edges unused
  ictcs_sync #(.WIDTH(PAIRS)) u_lock_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(dig_lock_in),
    .level_out(lock_s),
    .rise_out()
  );

  // only reference and tick edges matter
  ictcs_sync #(.WIDTH(3)) u_ref_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(asy_bus),
    .level_out(),
    .rise_out(ref_rise)
  );

  ////////////////////////////////////////////////////////////
  // per-pair input source selection
  genvar gi;
  generate
    for (gi = 0; gi < PAIRS; gi = gi + 1) begin : g_pair
      assign want_dig[gi] = cfg_default | pair_digital_cfg[gi];
      assign pair_next[gi] = want_dig[gi] & lock_s[gi];
    end
  endgenerate

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pair_use_digital <= {PAIRS{1'b0}};
    end else begin
      pair_use_digital <= pair_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // reference presence detection
  reg [15:0] video_to_reg;
  reg [15:0] word_to_reg;
  wire video_ok;
  wire word_ok;
  wire any_lock;

  assign video_ok = (video_to_reg != `ICTCS_REF_TO_ZERO);
  assign word_ok = (word_to_reg != `ICTCS_REF_TO_ZERO);
  assign any_lock = |(lock_s & want_dig);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      video_to_reg <= `ICTCS_REF_TO_ZERO;
      word_to_reg <= `ICTCS_REF_TO_ZERO;
    end else begin
      if (ref_rise[0]) begin
        video_to_reg <= `ICTCS_REF_TIMEOUT;
      end else if (video_ok) begin
        video_to_reg <= video_to_reg - `ICTCS_ONE16;
      end
      if (ref_rise[1]) begin
        word_to_reg <= `ICTCS_REF_TIMEOUT;
      end else if (word_ok) begin
        word_to_reg <= word_to_reg - `ICTCS_ONE16;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // master clock source and indicators
  reg [1:0] src_next;

  always @* begin
    src_next = `ICTCS_SRC_INTERNAL;
    case (master_clock_sel)
      `ICTCS_CLK_DIGITAL: begin
        src_next = any_lock ? `ICTCS_SRC_DIGITAL : `ICTCS_SRC_INTERNAL;
      end
      `ICTCS_CLK_EXTERNAL: begin
        if (video_ok) begin
          src_next = `ICTCS_SRC_VIDEO;
        end else if (word_ok) begin
          src_next = `ICTCS_SRC_WORD;
        end else begin
          src_next = `ICTCS_SRC_INTERNAL;
        end
      end
      default: begin
        src_next = `ICTCS_SRC_INTERNAL;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_source <= `ICTCS_SRC_INTERNAL;
      digital_lock_indicator <= 1'b0;
      digital_icon <= 1'b0;
      internal_clock_indicator <= 1'b1;
    end else begin
      clock_source <= src_next;
      digital_lock_indicator <= (src_next == `ICTCS_SRC_DIGITAL);
      digital_icon <= (src_next == `ICTCS_SRC_DIGITAL);
      internal_clock_indicator <= (src_next == `ICTCS_SRC_INTERNAL);
    end
  end

  ////////////////////////////////////////////////////////////
  // rate flash warning
  reg [7:0] flash_cnt_reg;
  reg flash_ph_reg;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_cnt_reg <= `ICTCS_ZERO8;
      flash_ph_reg <= 1'b0;
      rate_flash <= 1'b0;
    end else begin
      if (ref_rise[2]) begin
        if (flash_cnt_reg >= FLASH_DIV[7:0] - `ICTCS_ONE8) begin
          flash_cnt_reg <= `ICTCS_ZERO8;
          flash_ph_reg <= ~flash_ph_reg;
        end else begin
          flash_cnt_reg <= flash_cnt_reg + `ICTCS_ONE8;
        end
      end
      rate_flash <= incoming_timecode_view & incoming_tc_valid & flash_ph_reg &
        (incoming_frame_rate != frame_rate_sel);
    end
  end

  ////////////////////////////////////////////////////////////
  // time code generator
  reg st_reg;
  reg [31:0] last_rec_reg;
  reg [7:0] fmax;
  reg drop;
  wire [7:0] hh = tc_value[31:24];
  wire [7:0] mm = tc_value[23:16];
  wire [7:0] ss = tc_value[15:8];
  wire [7:0] ff = tc_value[7:0];
  reg [31:0] tc_inc;
  reg [31:0] start_val;

  // last frame number within a second and drop-frame per rate
  always @* begin
    fmax = `ICTCS_FMAX_30;
    drop = 1'b0;
    case (frame_rate_sel)
      `ICTCS_FR_23976: fmax = `ICTCS_FMAX_24;
      `ICTCS_FR_24: fmax = `ICTCS_FMAX_24;
      `ICTCS_FR_25: fmax = `ICTCS_FMAX_25;
      `ICTCS_FR_2997: fmax = `ICTCS_FMAX_30;
      `ICTCS_FR_2997DF: begin
        fmax = `ICTCS_FMAX_30;
        drop = 1'b1;
      end
      `ICTCS_FR_30DF: begin
        fmax = `ICTCS_FMAX_30;
        drop = 1'b1;
      end
      default: fmax = `ICTCS_FMAX_30;
    endcase
  end

  // one frame step, wraps at midnight
  always @* begin
    tc_inc = tc_value;
    if (ff < fmax) begin
      tc_inc[7:0] = ff + `ICTCS_ONE8;
    end else begin
      tc_inc[7:0] = `ICTCS_ZERO8;
      if (ss < `ICTCS_SEC_MAX) begin
        tc_inc[15:8] = ss + `ICTCS_ONE8;
      end else begin
        tc_inc[15:8] = `ICTCS_ZERO8;
        if (mm < `ICTCS_MIN_MAX) begin
          tc_inc[23:16] = mm + `ICTCS_ONE8;
          // skip frames 0 and 1 except every tenth minute
          if (drop && ((mm + `ICTCS_ONE8) % `ICTCS_TEN8 != `ICTCS_ZERO8)) begin
            tc_inc[7:0] = `ICTCS_TWO8;
          end
        end else begin
          tc_inc[23:16] = `ICTCS_ZERO8;
          tc_inc[31:24] = (hh < `ICTCS_HOUR_MAX) ? hh + `ICTCS_ONE8 : `ICTCS_ZERO8;
        end
      end
    end
  end

  always @* begin
    start_val = tc_value;
    case (timecode_generator_mode_switch)
      `ICTCS_GEN_RTC: start_val = rtc_value;
      `ICTCS_GEN_CONTINUE: start_val = last_rec_reg;
      `ICTCS_GEN_EXTERNAL: start_val = incoming_tc_valid ? incoming_tc_value : tc_value;
      default: start_val = tc_value;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      tc_value <= `ICTCS_TC_ZERO;
      last_rec_reg <= `ICTCS_TC_ZERO;
      tc_rate <= `ICTCS_FR_30;
      tc_drop_frame <= 1'b0;
    end else begin
      tc_rate <= frame_rate_sel;
      tc_drop_frame <= drop;
      case (st_reg)
        ST_IDLE: begin
          if (record_active) begin
            tc_value <= start_val;
            st_reg <= ST_RUN;
          end else if (timecode_generator_mode_switch == `ICTCS_GEN_FREE && ref_rise[2]) begin
            tc_value <= tc_inc;
          end
        end
        ST_RUN: begin
          if (!record_active) begin
            last_rec_reg <= tc_value;
            st_reg <= ST_IDLE;
          end else if (ref_rise[2]) begin
            tc_value <= tc_inc;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: dv/ictcs_properties.sv
// concurrent checks on the selector ports
`timescale 1ns/100ps
module ictcs_properties #(
  parameter PAIRS = 3
) (
  input wire clk_sys,
  input wire rst,
  input wire [PAIRS-1:0] pair_digital_cfg,
  input wire cfg_default,
  input wire [PAIRS-1:0] dig_lock_in,
  input wire [2:0] frame_rate_sel,
  input wire incoming_tc_valid,
  input wire [31:0] incoming_tc_value,
  input wire [31:0] rtc_value,
  input wire [1:0] timecode_generator_mode_switch,
  input wire record_active,
  input wire [PAIRS-1:0] pair_use_digital,
  input wire [1:0] clock_source,
  input wire digital_lock_indicator,
  input wire digital_icon,
  input wire internal_clock_indicator,
  input wire [31:0] tc_value,
  input wire [2:0] tc_rate,
  input wire tc_drop_frame
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_RATE_COPY: assert property (
    (frame_rate_sel != 3'h7 && $stable(frame_rate_sel))[*3] |-> tc_rate == frame_rate_sel)
    else $error("rate copy wrong");
  AST_DROP_FLAG: assert property (
    $stable(frame_rate_sel)[*3] |-> tc_drop_frame == (frame_rate_sel == 3'h4 || frame_rate_sel == 3'h5))
    else $error("drop flag wrong");
  AST_DIG_REPORT: assert property (
    digital_lock_indicator |-> clock_source == 2'h1 && digital_icon)
    else $error("digital report wrong");
  AST_INT_REPORT: assert property (
    internal_clock_indicator == (clock_source == 2'h0))
    else $error("internal report wrong");
  AST_FALLBACK: assert property (
    (!dig_lock_in[0])[*4] |-> !pair_use_digital[0])
    else $error("pair kept digital");
  AST_CFG_FORCE: assert property (
    (!cfg_default && !pair_digital_cfg[1])[*2] |-> !pair_use_digital[1])
    else $error("pair not forced analog");
  AST_RTC_LOAD: assert property (
    $rose(record_active) && timecode_generator_mode_switch == 2'h0 |=> tc_value == $past(rtc_value))
    else $error("rtc start wrong");
  AST_INCOMING_LOAD: assert property (
    $rose(record_active) && timecode_generator_mode_switch == 2'h3 && incoming_tc_valid
    |=> tc_value == $past(incoming_tc_value))
    else $error("external start wrong");
  AST_INCOMING_REFUSE: assert property (
    $rose(record_active) && timecode_generator_mode_switch == 2'h3 && !incoming_tc_valid |=> $stable(tc_value))
    else $error("refused start changed value");
endmodule

bind ictcs_top ictcs_properties #(.PAIRS(PAIRS)) u_props (.clk_sys, .rst, .pair_digital_cfg,
  .cfg_default, .dig_lock_in, .frame_rate_sel, .incoming_tc_valid, .incoming_tc_value, .rtc_value,
  .timecode_generator_mode_switch, .record_active, .pair_use_digital, .clock_source,
  .digital_lock_indicator, .digital_icon, .internal_clock_indicator, .tc_value, .tc_rate,
  .tc_drop_frame);

// file: dv/ictcs_src_model.sv
// far-side reference clocks and frame tick source
`timescale 1ns/100ps
module ictcs_src_model (
  output reg frame_tick,
  output reg video_ref,
  output reg word_ref
);
  reg video_on = 1'h0;
  reg word_on = 1'h0;
  // idle levels at start
  initial begin
    frame_tick = 1'h0;
    video_ref = 1'h0;
    word_ref = 1'h0;
  end
  always #24 video_ref = video_on & ~video_ref;
  always #24 word_ref = word_on & ~word_ref;
  task send_ticks(input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      #24 frame_tick = 1'h1;
      #24 frame_tick = 1'h0;
    end
  endtask
endmodule

// file: dv/ictcs_top_test.sv
// self-checking bench for the selector
`timescale 1ns/100ps
module ictcs_top_test;
  reg clk_sys = 1'h0;
  reg rst = 1'h1;
  reg [2:0] pair_digital_cfg = 3'h0;
  reg cfg_default = 1'h1;
  reg [2:0] dig_lock_in = 3'h0;
  reg [1:0] master_clock_sel = 2'h0;
  reg [2:0] frame_rate_sel = 3'h6;
  reg [2:0] incoming_frame_rate = 3'h6;
  reg incoming_tc_valid = 1'h0;
  reg [31:0] incoming_tc_value = 32'h0;
  reg [31:0] rtc_value = 32'h0;
  reg [1:0] gen_mode = 2'h0;
  reg record_active = 1'h0;
  reg incoming_timecode_view = 1'h0;
  reg seen;
  wire ftick, vref, wref, digital_lock_indicator, digital_icon, internal_clock_indicator, tc_drop_frame, rate_flash;
  wire [2:0] pair_use_digital;
  wire [1:0] clock_source;
  wire [31:0] tc_value;
  wire [2:0] tc_rate;
  integer n_errors = 0;
  integer compares = 0;
  integer i;
  // clock
  always #2.5 clk_sys = ~clk_sys;
  ictcs_src_model src (.frame_tick(ftick), .video_ref(vref), .word_ref(wref));
  ictcs_top dut (.clk_sys, .rst, .pair_digital_cfg, .cfg_default, .dig_lock_in, .master_clock_sel,
    .video_ref_in(vref), .word_ref_in(wref), .frame_rate_sel, .incoming_frame_rate, .incoming_tc_valid,
    .incoming_tc_value, .rtc_value, .timecode_generator_mode_switch(gen_mode), .record_active,
    .incoming_timecode_view, .frame_tick_in(ftick), .pair_use_digital, .clock_source,
    .digital_lock_indicator, .digital_icon, .internal_clock_indicator, .tc_value, .tc_rate,
    .tc_drop_frame, .rate_flash);
  ////////////////////////////////////////
  task check(input string what, input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %0s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task look(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task rec(input [1:0] m, input [2:0] r, input v, input [31:0] st, input [31:0] e0, input integer nt,
    input [31:0] e1);
    @(posedge clk_sys);
    gen_mode <= m;
    frame_rate_sel <= r;
    incoming_tc_valid <= v;
    incoming_tc_value <= st;
    rtc_value <= st;
    repeat (4) @(posedge clk_sys);
    record_active <= 1'h1;
    look(2);
    check("tc start", tc_value, e0);
    src.send_ticks(nt);
    look(6);
    check("tc count", tc_value, e1);
    @(posedge clk_sys);
    record_active <= 1'h0;
    look(3);
  endtask
  task end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #400000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (15) @(posedge clk_sys);
    #1;
    check("reset pairs", pair_use_digital, 3'h0);
    check("reset int", internal_clock_indicator, 1'h1);
    check("reset rate", tc_rate, 3'h6);
    @(posedge clk_sys);
    rst <= 1'h0;
    dig_lock_in <= 3'h7;
    look(6);
    check("pairs", pair_use_digital, 3'h7);
    @(posedge clk_sys);
    dig_lock_in <= 3'h5;
    look(6);
    check("pairs", pair_use_digital, 3'h5);
    @(posedge clk_sys);
    dig_lock_in <= 3'h7;
    look(6);
    check("pairs", pair_use_digital, 3'h7);
    @(posedge clk_sys);
    cfg_default <= 1'h0;
    pair_digital_cfg <= 3'h1;
    look(4);
    check("pairs", pair_use_digital, 3'h1);
    @(posedge clk_sys);
    cfg_default <= 1'h1;
    master_clock_sel <= 2'h1;
    look(4);
    check("clk src", clock_source, 2'h1);
    check("dig icon", {digital_lock_indicator, digital_icon}, 2'h3);
    @(posedge clk_sys);
    dig_lock_in <= 3'h0;
    look(6);
    check("int src", {clock_source, internal_clock_indicator}, 3'h1);
    @(posedge clk_sys);
    master_clock_sel <= 2'h2;
    src.video_on = 1'h1;
    look(40);
    check("video src", clock_source, 2'h2);
    src.video_on = 1'h0;
    src.word_on = 1'h1;
    look(1100);
    check("word src", clock_source, 2'h3);
    src.word_on = 1'h0;
    $display("test clocks done");
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge clk_sys);
      frame_rate_sel <= i[2:0];
      look(3);
      check("rate", {tc_drop_frame, tc_rate}, {i == 4 || i == 5, i[2:0]});
    end
    rec(2'h0, 3'h2, 1'h0, 32'h01020318, 32'h01020318, 1, 32'h01020400);
    rec(2'h0, 3'h5, 1'h0, 32'h01003b1d, 32'h01003b1d, 1, 32'h01010002);
    rec(2'h0, 3'h6, 1'h0, 32'h01003b1d, 32'h01003b1d, 1, 32'h01010000);
    rec(2'h1, 3'h6, 1'h0, 32'h0, 32'h01010000, 1, 32'h01010001);
    rec(2'h3, 3'h6, 1'h1, 32'h02030405, 32'h02030405, 1, 32'h02030406);
    rec(2'h3, 3'h6, 1'h0, 32'h05000000, 32'h02030406, 0, 32'h02030406);
    @(posedge clk_sys);
    gen_mode <= 2'h2;
    src.send_ticks(1);
    look(6);
    check("free run", tc_value, 32'h02030407);
    $display("test generator done");
    @(posedge clk_sys);
    incoming_timecode_view <= 1'h1;
    incoming_tc_valid <= 1'h1;
    incoming_frame_rate <= 3'h0;
    seen = 1'h0;
    for (i = 0; i < 50; i = i + 1) begin
      src.send_ticks(1);
      seen = seen | rate_flash;
    end
    check("flash", seen, 1'h1);
    @(posedge clk_sys);
    incoming_frame_rate <= 3'h6;
    look(6);
    seen = 1'h0;
    for (i = 0; i < 30; i = i + 1) begin
      src.send_ticks(1);
      seen = seen | rate_flash;
    end
    check("no flash", seen, 1'h0);
    $display("test flash done");
    end_of_test;
  end
endmodule
